// file: bench/sfci_props.sv
/*
  Pin-level assertions on the link between host and flash ends.
  Assumes the pins are sampled on the shared system clock.
*/
`timescale 1ns/1ns
module sfci_props (
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic rst_n,
  input wire logic so,
  input wire logic so_oe
);
  logic sck_reg;
  logic sck_next;
  logic [3:0] age_reg;
  logic [3:0] age_next;
  // Cycles since the last falling serial clock edge; the flash end lags a pin edge.
  always_comb
  begin
    sck_next = sck;
    age_next = (age_reg == 4'hf) ? age_reg : age_reg + 4'h1;
    if (sck_reg && !sck)
      age_next = 4'h0;
    if (RESET_I)
      age_next = 4'hf;
  end
  always_ff @(posedge SYS_CLK_I)
  begin
    sck_reg <= sck_next;
    age_reg <= age_next;
  end
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RESET_I);
  sequence s_frame_end;
    $rose(cs_n);
  endsequence
  sequence s_off_soon;
    ##[1:6] !so_oe;
  endsequence
  property p_so_fall;
    so_oe && $past(so_oe) && (so != $past(so)) |-> age_reg inside {[4'h1:4'h4]};
  endproperty
  property p_oe_fall;
    $rose(so_oe) |-> !cs_n && age_reg inside {[4'h1:4'h4]};
  endproperty
  property p_release;
    s_frame_end |-> s_off_soon;
  endproperty
  property p_idle_off;
    cs_n [*8] |-> !so_oe;
  endproperty
  property p_si_rise;
    !cs_n && !$past(cs_n) && (si != $past(si)) |-> $rose(sck);
  endproperty
  property p_sck_still;
    cs_n && $past(cs_n) |-> $stable(sck);
  endproperty
  property p_half;
    $changed(sck) && !cs_n |=> $stable(sck) [*3];
  endproperty
  property p_rst_cs;
    !rst_n |-> cs_n;
  endproperty
  property p_rst_rel;
    $rose(rst_n) |-> $past(cs_n);
  endproperty
  a_so_fall: assert property (p_so_fall)
    else $error("so changed away from a falling clock edge");
  a_oe_fall: assert property (p_oe_fall)
    else $error("so enabled out of frame or off a falling edge");
  a_release: assert property (p_release)
    else $error("so still driven after select rose");
  a_idle_off: assert property (p_idle_off)
    else $error("so driven while deselected");
  a_si_rise: assert property (p_si_rise)
    else $error("si changed away from a rising clock edge");
  a_sck_still: assert property (p_sck_still)
    else $error("serial clock moved outside a frame");
  a_half: assert property (p_half)
    else $error("serial clock half period too short");
  a_rst_cs: assert property (p_rst_cs)
    else $error("select low while flash reset held");
  a_rst_rel: assert property (p_rst_rel)
    else $error("flash reset released with select low");
endmodule

// file: bench/tb_top.sv
/*
  Self-checking bench: host and flash ends joined through one pin bundle.
  Assumes the package constants and the host start and busy handshake.
*/
`timescale 1ns/1ns
module tb_top;
  import sfci_pkg::*;
  localparam logic [7:0] STAT = 8'ha6;
  localparam logic [63:0] PROT = 64'h8877665544332211;
  localparam logic [63:0] LOCK = 64'h0f1e2d3c4b5a6978;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic we = 1'b0;
  logic [MEM_AW-1:0] la = 6'h00;
  logic [7:0] ld = 8'h00;
  logic start = 1'b0;
  logic [7:0] op = 8'h00;
  logic [23:0] addr = 24'h000000;
  logic [2:0] hdr = 3'h0;
  logic [7:0] nrd = 8'h00;
  logic m3 = 1'b0;
  logic prog = 1'b0;
  logic arw = 1'b0;
  logic busy;
  logic [7:0] rdat;
  logic rvld;
  logic due;
  logic [10:0] page;
  logic [7:0] dop;
  logic dvld;
  logic [7:0] gop;
  logic [7:0] got [$];
  int fail_count = 0;
  int num_checks = 0;
  always #2 clk = ~clk;
  sfci_if u_sfci_if ();
  sfci_host u_sfci_host (.SYS_CLK_I(clk), .RESET_I(rst), .BUS(u_sfci_if.host),
    .START_I(start), .OPCODE_I(op), .ADDR_I(addr), .HDR_BYTES_I(hdr), .RD_BYTES_I(nrd),
    .MODE3_I(m3), .IS_PROG_I(prog), .AUTO_RW_I(arw), .BUSY_O(busy), .RD_DATA_O(rdat),
    .RD_VALID_O(rvld), .REWRITE_DUE_O(due), .REWRITE_PAGE_O(page));
  sfci_dev u_sfci_dev (.SYS_CLK_I(clk), .RESET_I(rst), .BUS(u_sfci_if.dev), .LOAD_WE_I(we),
    .LOAD_ADDR_I(la), .LOAD_DATA_I(ld), .STATUS_I(STAT), .PROT_I(PROT), .LOCK_I(LOCK),
    .OPCODE_O(dop), .OPCODE_VALID_O(dvld));
  sfci_props u_sfci_props (.SYS_CLK_I(clk), .RESET_I(rst), .sck(u_sfci_if.sck),
    .cs_n(u_sfci_if.cs_n), .si(u_sfci_if.si), .rst_n(u_sfci_if.rst_n), .so(u_sfci_if.so),
    .so_oe(u_sfci_if.so_oe));
  function automatic logic [7:0] mv(input int a);
    return 8'(a * 7 + 3);
  endfunction
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // One whole command; the answer bytes are gathered while the host is busy.
  task automatic xfer(input logic [7:0] o, input logic [23:0] a, input logic [2:0] h,
    input logic [7:0] n, input logic md, input logic pg, input logic ar);
    int i;
    got.delete();
    gop = 8'hxx;
    @(posedge clk);
    op <= o;
    addr <= a;
    hdr <= h;
    nrd <= n;
    m3 <= md;
    prog <= pg;
    arw <= ar;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(negedge clk);
    check("sck idle level", u_sfci_if.sck, md);
    for (i = 0; i < 4000 && busy === 1'b1; i++)
    begin
      if (rvld === 1'b1)
        got.push_back(rdat);
      if (dvld === 1'b1)
        gop = dop;
      @(negedge clk);
    end
    if (i == 4000)
    begin
      fail_count++;
      conclude();
    end
    check("opcode seen", gop, o);
    check("byte count", got.size(), n);
    check("so released", u_sfci_if.so_line, 1'b1);
  endtask
  // Reads that cross the end of the main array wrap to its start.
  task automatic sc_array();
    logic [7:0] ops [4] = '{OP_CAR_LEGACY, OP_CAR_HS, OP_CAR_LF, OP_PAGE_RD};
    logic [2:0] hb [4] = '{3'h7, 3'h4, 3'h3, 3'h7};
    for (int k = 0; k < 4; k++)
    begin
      xfer(ops[k], 24'h00001e, hb[k], 8'h04, k[0], 1'b0, 1'b0);
      for (int j = 0; j < 4; j++)
        check("array byte", got[j], mv((30 + j) % 32));
    end
  endtask
  task automatic sc_buffers();
    logic [7:0] ops [4] = '{OP_BUF1_RD, OP_BUF1_LF, OP_BUF2_RD, OP_BUF2_LF};
    logic [2:0] hb [4] = '{3'h4, 3'h3, 3'h4, 3'h3};
    int base [4] = '{32, 32, 40, 40};
    for (int k = 0; k < 4; k++)
    begin
      xfer(ops[k], 24'h000006, hb[k], 8'h03, k[1], 1'b0, 1'b0);
      for (int j = 0; j < 3; j++)
        check("buffer byte", got[j], mv(base[k] + ((6 + j) % 8)));
    end
  endtask
  task automatic sc_regs();
    logic [7:0] ids [4] = '{ID_BYTE0, ID_BYTE1, ID_BYTE2, ID_BYTE3};
    xfer(OP_PROT_RD, 24'h000005, 3'h3, 8'h04, 1'b0, 1'b0, 1'b0);
    for (int j = 0; j < 4; j++)
      check("protection byte", got[j], PROT[8 * ((5 + j) % 8) +: 8]);
    xfer(OP_LOCK_RD, 24'h000005, 3'h3, 8'h04, 1'b1, 1'b0, 1'b0);
    for (int j = 0; j < 4; j++)
      check("lockdown byte", got[j], LOCK[8 * ((5 + j) % 8) +: 8]);
    xfer(OP_SEC_RD, 24'h00000e, 3'h3, 8'h03, 1'b0, 1'b0, 1'b0);
    for (int j = 0; j < 3; j++)
      check("security byte", got[j], mv(48 + ((14 + j) % 16)));
    xfer(OP_STAT_RD, 24'h000000, 3'h0, 8'h02, 1'b1, 1'b0, 1'b0);
    for (int j = 0; j < 2; j++)
      check("status byte", got[j], STAT);
    xfer(OP_ID_RD, 24'h000000, 3'h0, 8'h04, 1'b0, 1'b0, 1'b0);
    for (int j = 0; j < 4; j++)
      check("id byte", got[j], ids[j]);
  endtask
  // The rewrite read ignores its own address and uses the pointer page.
  task automatic sc_rewrite();
    for (int k = 0; k < 4; k++)
    begin
      check("due early", due, 1'b0);
      xfer(8'h82, 24'h000000, 3'h3, 8'h00, 1'b0, 1'b1, 1'b0);
    end
    check("due", due, 1'b1);
    check("pointer", page, 11'h000);
    xfer(OP_CAR_LF, 24'h000005, 3'h3, 8'h02, 1'b1, 1'b0, 1'b1);
    check("rewrite data", got[0], mv(0));
    check("due cleared", due, 1'b0);
    check("pointer step", page, 11'h001);
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < MEM_DEPTH; a++)
    begin
      @(posedge clk);
      we <= 1'b1;
      la <= 6'(a);
      ld <= mv(a);
    end
    @(posedge clk);
    we <= 1'b0;
    repeat (4) @(posedge clk);
    sc_array();
    sc_buffers();
    sc_regs();
    sc_rewrite();
    conclude();
  end
endmodule

// file: hw/sfci_dev.sv
/*
  Flash end of the serial command interface: samples the pins, decodes the
  read opcodes and streams bytes from flop storage, status, id and
  protection inputs.
  Assumes the serial clock is at most an eighth of the system clock.
*/
// How it works
// [R1] Drive output on falling, sample on rising.
// [R2] Host captures output on the following fall.
// [R3] Host launches input bits on rising edges.
// [R4] Works with idle-low and idle-high clock framing.
// [R5] Host keeps select high before releasing reset.
// [R6] Opcode E8 streams main array sequentially.
// [R7] Opcode 0B streams main array, one dummy.
// [R8] Opcode 03 streams main array, no dummy.
// [R9] Opcode D2 reads a main memory page.
// [R10] Opcodes D4/D6 read buffer one/two.
// [R11] Opcodes D1/D3 read buffers at low speed.
// [R12] Opcode 32 returns sector protection bytes.
// [R13] Opcode 35 returns sector lockdown bytes.
// [R14] Opcode 77 returns security register bytes.
// [R15] Opcode D7 returns the status byte.
// [R16] Opcode 9F returns identification bytes.
// [R17] Host programs pages directly or via buffer.
// [R18] Host rewrites each page within 10000 operations.
// [R19] Host keeps a next-rewrite page pointer.
// [R20] Auto rewrite targets the pointer's page.
// [R21] First byte is opcode; select high ends.
`timescale 1ns/1ns
module sfci_dev (
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  sfci_if.dev BUS,
  input wire logic LOAD_WE_I,
  input wire logic [sfci_pkg::MEM_AW-1:0] LOAD_ADDR_I,
  input wire logic [7:0] LOAD_DATA_I,
  input wire logic [7:0] STATUS_I,
  input wire logic [63:0] PROT_I,
  input wire logic [63:0] LOCK_I,
  output logic [7:0] OPCODE_O,
  output logic OPCODE_VALID_O
);
  import sfci_pkg::*;

  typedef enum {PH_HDR, PH_DATA, PH_IGNORE} sfci_phase_t;
  logic [3:0] pins_s;
  logic sck_s;
  logic cs_n_s;
  logic si_s;
  logic rst_n_s;
  logic sel;
  logic rise;
  logic fall;
  logic [7:0] mem_reg [MEM_DEPTH];
  logic [7:0] mem_next [MEM_DEPTH];
  sfci_phase_t ph_reg, ph_next;
  logic sck_d_reg, sck_d_next;
  logic si_d_reg, si_d_next;
  logic [6:0] rx_cnt_reg, rx_cnt_next;
  logic [31:0] hdr_sr_reg, hdr_sr_next;
  logic [7:0] op_reg, op_next;
  logic [23:0] addr_reg, addr_next;
  logic [5:0] idx_reg, idx_next;
  logic [2:0] tx_cnt_reg, tx_cnt_next;
  logic [7:0] tx_sr_reg, tx_sr_next;
  logic so_reg, so_next;
  logic oe_reg, oe_next;
  logic opv_reg, opv_next;
  logic [7:0] op_now;
  logic [23:0] addr_now;
  logic [6:0] need_now;
  logic [7:0] fetch;

  // Header bits before output; zero marks an opcode this end does not serve.
  function automatic logic [6:0] hdr_bits(input logic [7:0] op);
    case (op)
      OP_CAR_LEGACY, OP_PAGE_RD: hdr_bits = HDR_ADDR_D4;
      OP_CAR_HS, OP_BUF1_RD, OP_BUF2_RD: hdr_bits = HDR_ADDR_D1;
      OP_CAR_LF, OP_BUF1_LF, OP_BUF2_LF: hdr_bits = HDR_ADDR;
      OP_PROT_RD, OP_LOCK_RD, OP_SEC_RD: hdr_bits = HDR_ADDR;
      OP_STAT_RD, OP_ID_RD: hdr_bits = HDR_OP_ONLY;
      default: hdr_bits = 7'h00;
    endcase
  endfunction

  sfci_sync #(.W(4)) u_sync (
    .SYS_CLK_I(SYS_CLK_I),
    .RESET_I(RESET_I),
    .D_I({BUS.sck, BUS.cs_n, BUS.si, BUS.rst_n}),
    .Q_O(pins_s)
  );

  assign sck_s = pins_s[3];
  assign cs_n_s = pins_s[2];
  assign si_s = pins_s[1];
  assign rst_n_s = pins_s[0];
  assign sel = !cs_n_s && rst_n_s;
  // [R1] Edge detect on sampled clock.
  assign rise = sck_s && !sck_d_reg;
  assign fall = !sck_s && sck_d_reg;

  genvar i;
  generate
    for (i = 0; i < MEM_DEPTH; i++)
    begin : g_mem
      always_comb
      begin
        mem_next[i] = mem_reg[i];
        if (LOAD_WE_I && (LOAD_ADDR_I == 6'(i)))
        begin
          mem_next[i] = LOAD_DATA_I;
        end
      end
      always_ff @(posedge SYS_CLK_I)
      begin
        if (RESET_I)
        begin
          mem_reg[i] <= 8'h00;
        end
        else
        begin
          mem_reg[i] <= mem_next[i];
        end
      end
    end
  endgenerate

  always_comb
  begin
    case (op_reg)
      // [R6] [R7] [R8] [R9] Main array reads, wrapping within the 32 main-array bytes.
      OP_CAR_LEGACY, OP_CAR_HS, OP_CAR_LF, OP_PAGE_RD:
        fetch = mem_reg[{MAIN_BASE, idx_reg[4:0]}];
      // [R10] [R11] First and second buffer reads.
      OP_BUF1_RD, OP_BUF1_LF: fetch = mem_reg[{BUF1_BASE, idx_reg[2:0]}];
      OP_BUF2_RD, OP_BUF2_LF: fetch = mem_reg[{BUF2_BASE, idx_reg[2:0]}];
      // [R12] Sector protection bytes.
      OP_PROT_RD: fetch = PROT_I[{idx_reg[2:0], 3'h0} +: 8];
      // [R13] Sector lockdown bytes.
      OP_LOCK_RD: fetch = LOCK_I[{idx_reg[2:0], 3'h0} +: 8];
      // [R14] Security register bytes.
      OP_SEC_RD: fetch = mem_reg[{SEC_BASE, idx_reg[3:0]}];
      // [R15] Status repeats while clocked.
      OP_STAT_RD: fetch = STATUS_I;
      // [R16] Identification bytes in order.
      OP_ID_RD:
        case (idx_reg[1:0])
          2'h0: fetch = ID_BYTE0;
          2'h1: fetch = ID_BYTE1;
          2'h2: fetch = ID_BYTE2;
          default: fetch = ID_BYTE3;
        endcase
      default: fetch = 8'h00;
    endcase
  end

  // The host changes si on the sampling rise, so the value before it is used.
  assign op_now = (rx_cnt_reg == 7'h07) ? {hdr_sr_reg[6:0], si_d_reg} : op_reg;
  assign addr_now = (rx_cnt_reg == 7'h1f) ? {hdr_sr_reg[22:0], si_d_reg} : addr_reg;
  assign need_now = hdr_bits(op_now);

  always_comb
  begin
    ph_next = ph_reg;
    sck_d_next = sck_s;
    si_d_next = si_s;
    rx_cnt_next = rx_cnt_reg;
    hdr_sr_next = hdr_sr_reg;
    op_next = op_reg;
    addr_next = addr_reg;
    idx_next = idx_reg;
    tx_cnt_next = tx_cnt_reg;
    tx_sr_next = tx_sr_reg;
    so_next = so_reg;
    oe_next = oe_reg;
    opv_next = 1'b0;
    if (!sel)
    begin
      // [R21] Select high ends the command and releases the output.
      // Rise one carries no bit yet; a clock raised with select is no edge.
      ph_next = PH_HDR;
      sck_d_next = 1'b1;
      rx_cnt_next = 7'h7f;
      tx_cnt_next = 3'h0;
      so_next = 1'b0;
      oe_next = 1'b0;
    end
    else
    begin
      // [R1] [R4] Sample on rising; first edge of either framing is ignored.
      if (rise && (ph_reg == PH_HDR))
      begin
        hdr_sr_next = {hdr_sr_reg[30:0], si_d_reg};
        rx_cnt_next = 7'(rx_cnt_reg + 7'h01);
        // [R21] First byte taken as the opcode, msb first.
        if (rx_cnt_reg == 7'h07)
        begin
          op_next = op_now;
          opv_next = 1'b1;
          if (need_now == 7'h00)
          begin
            ph_next = PH_IGNORE;
          end
        end
        if (rx_cnt_reg == 7'h1f)
        begin
          addr_next = addr_now;
        end
        if ((need_now != 7'h00) && (7'(rx_cnt_reg + 7'h01) == need_now))
        begin
          ph_next = PH_DATA;
          idx_next = (need_now == HDR_OP_ONLY) ? 6'h00 : addr_now[5:0];
        end
      end
      // [R1] Output bits change only on falling edges.
      if (fall && (ph_reg == PH_DATA))
      begin
        oe_next = 1'b1;
        tx_cnt_next = 3'(tx_cnt_reg + 3'h1);
        if (tx_cnt_reg == 3'h0)
        begin
          so_next = fetch[7];
          tx_sr_next = {fetch[6:0], 1'b0};
          idx_next = 6'(idx_reg + 6'h01);
        end
        else
        begin
          so_next = tx_sr_reg[7];
          tx_sr_next = {tx_sr_reg[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (RESET_I)
    begin
      ph_reg <= PH_HDR;
      sck_d_reg <= 1'b0;
      si_d_reg <= 1'b0;
      rx_cnt_reg <= 7'h00;
      hdr_sr_reg <= 32'h00000000;
      op_reg <= 8'h00;
      addr_reg <= 24'h000000;
      idx_reg <= 6'h00;
      tx_cnt_reg <= 3'h0;
      tx_sr_reg <= 8'h00;
      so_reg <= 1'b0;
      oe_reg <= 1'b0;
      opv_reg <= 1'b0;
    end
    else
    begin
      ph_reg <= ph_next;
      sck_d_reg <= sck_d_next;
      si_d_reg <= si_d_next;
      rx_cnt_reg <= rx_cnt_next;
      hdr_sr_reg <= hdr_sr_next;
      op_reg <= op_next;
      addr_reg <= addr_next;
      idx_reg <= idx_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_sr_reg <= tx_sr_next;
      so_reg <= so_next;
      oe_reg <= oe_next;
      opv_reg <= opv_next;
    end
  end

  assign BUS.so = so_reg;
  assign BUS.so_oe = oe_reg;
  assign OPCODE_O = op_reg;
  assign OPCODE_VALID_O = opv_reg;
endmodule

// file: hw/sfci_host.sv
/*
  Host end: makes the serial clock by a divider, shifts out a command
  header, collects read bytes and keeps the page rewrite pointer.
  Assumes the flash end follows the full-cycle edge scheme.
*/
`timescale 1ns/1ns
module sfci_host (
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  sfci_if.host BUS,
  input wire logic START_I,
  input wire logic [7:0] OPCODE_I,
  input wire logic [23:0] ADDR_I,
  input wire logic [2:0] HDR_BYTES_I,
  input wire logic [7:0] RD_BYTES_I,
  input wire logic MODE3_I,
  input wire logic IS_PROG_I,
  input wire logic AUTO_RW_I,
  output logic BUSY_O,
  output logic [7:0] RD_DATA_O,
  output logic RD_VALID_O,
  output logic REWRITE_DUE_O,
  output logic [10:0] REWRITE_PAGE_O
);
  import sfci_pkg::*;

  typedef enum {H_IDLE, H_RUN, H_TAIL, H_GAP} sfci_hstate_t;

  sfci_hstate_t st_reg, st_next;
  logic so_s;
  logic tick;
  logic [11:0] fall_inc;
  logic [3:0] div_reg, div_next;
  logic [3:0] gap_reg, gap_next;
  logic sck_reg, sck_next;
  logic cs_n_reg, cs_n_next;
  logic rst_n_reg, rst_n_next;
  logic si_reg, si_next;
  logic m3_reg, m3_next;
  logic [63:0] tx_sr_reg, tx_sr_next;
  logic [6:0] hbits_reg, hbits_next;
  logic [6:0] rise_reg, rise_next;
  logic [11:0] fall_reg, fall_next;
  logic [11:0] nfall_reg, nfall_next;
  logic [7:0] rx_sr_reg, rx_sr_next;
  logic [2:0] rxb_reg, rxb_next;
  logic [7:0] rd_reg, rd_next;
  logic rdv_reg, rdv_next;
  logic [10:0] ptr_reg, ptr_next;
  logic [3:0] ops_reg, ops_next;
  logic [23:0] cmd_addr;

  sfci_sync #(.W(1)) u_sync (
    .SYS_CLK_I(SYS_CLK_I),
    .RESET_I(RESET_I),
    .D_I(BUS.so_line),
    .Q_O(so_s)
  );

  assign tick = (div_reg == 4'(SCK_HALF_CYC - 1));
  assign fall_inc = 12'(fall_reg + 12'h001);
  // [R20] An auto rewrite goes to the page held in the pointer.
  assign cmd_addr = AUTO_RW_I ? 24'(24'(ptr_reg) << PAGE_LSB) : ADDR_I;

  always_comb
  begin
    st_next = st_reg;
    div_next = div_reg;
    gap_next = gap_reg;
    sck_next = sck_reg;
    cs_n_next = cs_n_reg;
    // [R5] Reset is released only while select is held high.
    rst_n_next = rst_n_reg || cs_n_reg;
    si_next = si_reg;
    m3_next = m3_reg;
    tx_sr_next = tx_sr_reg;
    hbits_next = hbits_reg;
    rise_next = rise_reg;
    fall_next = fall_reg;
    nfall_next = nfall_reg;
    rx_sr_next = rx_sr_reg;
    rxb_next = rxb_reg;
    rd_next = rd_reg;
    rdv_next = 1'b0;
    ptr_next = ptr_reg;
    ops_next = ops_reg;
    case (st_reg)
      H_IDLE:
        // [R17] Any opcode is sent, so either page write route is open.
        if (START_I && rst_n_reg)
        begin
          st_next = H_RUN;
          cs_n_next = 1'b0;
          sck_next = MODE3_I;
          m3_next = MODE3_I;
          div_next = 4'h0;
          rise_next = 7'h00;
          fall_next = 12'h000;
          rxb_next = 3'h0;
          tx_sr_next = {OPCODE_I, cmd_addr, 32'h00000000};
          hbits_next = 7'({4'(HDR_BYTES_I) + 4'h1, 3'h0});
          nfall_next = 12'(12'(7'({4'(HDR_BYTES_I) + 4'h1, 3'h0})) + 12'h001
                       + {1'b0, RD_BYTES_I, 3'h0});
          // [R18] Count program operations against the rewrite interval.
          if (IS_PROG_I && (ops_reg != OPS_MAX))
          begin
            ops_next = 4'(ops_reg + 4'h1);
          end
          // [R19] Pointer advances with each auto rewrite.
          if (AUTO_RW_I)
          begin
            ptr_next = 11'(ptr_reg + 11'h001);
            ops_next = (ops_reg >= RW_INTERVAL) ? 4'(ops_reg - RW_INTERVAL) : 4'h0;
          end
        end
      H_RUN:
      begin
        div_next = tick ? 4'h0 : 4'(div_reg + 4'h1);
        if (tick)
        begin
          sck_next = !sck_reg;
          if (!sck_reg)
          begin
            // [R3] Each header bit is launched on a rising edge.
            rise_next = 7'(rise_reg + 7'h01);
            if (rise_reg < hbits_reg)
            begin
              si_next = tx_sr_reg[63];
              tx_sr_next = {tx_sr_reg[62:0], 1'b0};
            end
          end
          else if (rise_reg != 7'h00)
          begin
            fall_next = fall_inc;
            // [R2] Capture on the fall after the one that launched the bit.
            if (fall_inc >= 12'(12'(hbits_reg) + 12'h002))
            begin
              rx_sr_next = {rx_sr_reg[6:0], so_s};
              rxb_next = 3'(rxb_reg + 3'h1);
              if (rxb_reg == 3'h7)
              begin
                rd_next = {rx_sr_reg[6:0], so_s};
                rdv_next = 1'b1;
              end
            end
            if (fall_inc == nfall_reg)
            begin
              st_next = m3_reg ? H_TAIL : H_GAP;
              div_next = 4'h0;
            end
          end
        end
      end
      H_TAIL:
      begin
        // Idle-high framing must return the clock high before select rises.
        div_next = tick ? 4'h0 : 4'(div_reg + 4'h1);
        if (tick)
        begin
          sck_next = 1'b1;
          st_next = H_GAP;
        end
      end
      H_GAP:
      begin
        cs_n_next = 1'b1;
        gap_next = 4'(gap_reg + 4'h1);
        if (gap_reg == 4'(T_CS_CYC - 1))
        begin
          gap_next = 4'h0;
          st_next = H_IDLE;
        end
      end
      default: st_next = H_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (RESET_I)
    begin
      st_reg <= H_IDLE;
      div_reg <= 4'h0;
      gap_reg <= 4'h0;
      sck_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      rst_n_reg <= 1'b0;
      si_reg <= 1'b0;
      m3_reg <= 1'b0;
      tx_sr_reg <= 64'h0000000000000000;
      hbits_reg <= 7'h00;
      rise_reg <= 7'h00;
      fall_reg <= 12'h000;
      nfall_reg <= 12'h000;
      rx_sr_reg <= 8'h00;
      rxb_reg <= 3'h0;
      rd_reg <= 8'h00;
      rdv_reg <= 1'b0;
      ptr_reg <= 11'h000;
      ops_reg <= 4'h0;
    end
    else
    begin
      st_reg <= st_next;
      div_reg <= div_next;
      gap_reg <= gap_next;
      sck_reg <= sck_next;
      cs_n_reg <= cs_n_next;
      rst_n_reg <= rst_n_next;
      si_reg <= si_next;
      m3_reg <= m3_next;
      tx_sr_reg <= tx_sr_next;
      hbits_reg <= hbits_next;
      rise_reg <= rise_next;
      fall_reg <= fall_next;
      nfall_reg <= nfall_next;
      rx_sr_reg <= rx_sr_next;
      rxb_reg <= rxb_next;
      rd_reg <= rd_next;
      rdv_reg <= rdv_next;
      ptr_reg <= ptr_next;
      ops_reg <= ops_next;
    end
  end

  assign BUS.sck = sck_reg;
  assign BUS.cs_n = cs_n_reg;
  assign BUS.si = si_reg;
  assign BUS.rst_n = rst_n_reg;
  assign BUSY_O = (st_reg != H_IDLE);
  assign RD_DATA_O = rd_reg;
  assign RD_VALID_O = rdv_reg;
  assign REWRITE_DUE_O = (ops_reg >= RW_INTERVAL);
  assign REWRITE_PAGE_O = ptr_reg;
endmodule

// file: hw/sfci_if.sv
/*
  Pin bundle between the host and the flash end.
  Assumes a pull-up on the serial output line while it is not driven.
*/
`timescale 1ns/1ns
interface sfci_if;
  logic sck;
  logic cs_n;
  logic si;
  logic rst_n;
  logic so;
  logic so_oe;
  wire so_line = so_oe ? so : 1'b1;
  modport host (output sck, output cs_n, output si, output rst_n, input so_line);
  modport dev (input sck, input cs_n, input si, input rst_n, output so, output so_oe);
endinterface

// file: hw/sfci_pkg.sv
/*
  Shared constants of the serial flash command interface: opcodes, header
  lengths, storage map, link timing and host rewrite policy.
  Assumes a 250 MHz system clock on both ends.
*/
package sfci_pkg;
  localparam int SYS_PERIOD_NS = 4;
  // Host-made serial clock; 32 ns keeps well under the 66 MHz ceiling.
  localparam int SCK_PERIOD_NS = 32;
  localparam int SCK_HALF_CYC = SCK_PERIOD_NS / (2 * SYS_PERIOD_NS);
  localparam int T_CS_NS = 50;
  localparam int T_CS_CYC = (T_CS_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

  localparam logic [7:0] OP_CAR_LEGACY = 8'he8;
  localparam logic [7:0] OP_CAR_HS = 8'h0b;
  localparam logic [7:0] OP_CAR_LF = 8'h03;
  localparam logic [7:0] OP_PAGE_RD = 8'hd2;
  localparam logic [7:0] OP_BUF1_RD = 8'hd4;
  localparam logic [7:0] OP_BUF2_RD = 8'hd6;
  localparam logic [7:0] OP_BUF1_LF = 8'hd1;
  localparam logic [7:0] OP_BUF2_LF = 8'hd3;
  localparam logic [7:0] OP_PROT_RD = 8'h32;
  localparam logic [7:0] OP_LOCK_RD = 8'h35;
  localparam logic [7:0] OP_SEC_RD = 8'h77;
  localparam logic [7:0] OP_STAT_RD = 8'hd7;
  localparam logic [7:0] OP_ID_RD = 8'h9f;

  // Header length in bits, opcode included, before the first output bit.
  localparam logic [6:0] HDR_OP_ONLY = 7'h08;
  localparam logic [6:0] HDR_ADDR = 7'h20;
  localparam logic [6:0] HDR_ADDR_D1 = 7'h28;
  localparam logic [6:0] HDR_ADDR_D4 = 7'h40;

  // Identification bytes; the values are arbitrary.
  localparam logic [7:0] ID_BYTE0 = 8'h5a;
  localparam logic [7:0] ID_BYTE1 = 8'h24;
  localparam logic [7:0] ID_BYTE2 = 8'h00;
  localparam logic [7:0] ID_BYTE3 = 8'h00;

  // Flop storage: 32 main-array bytes, two 8-byte buffers, 16 security bytes.
  localparam int MEM_AW = 6;
  localparam int MEM_DEPTH = 64;
  localparam logic [0:0] MAIN_BASE = 1'b0;
  localparam logic [2:0] BUF1_BASE = 3'h4;
  localparam logic [2:0] BUF2_BASE = 3'h5;
  localparam logic [1:0] SEC_BASE = 2'h3;

  // Page address field of a 264-byte page layout.
  localparam int PAGE_LSB = 9;
  // 2048 pages at one rewrite per 4 operations cover the array in 8192.
  localparam logic [3:0] RW_INTERVAL = 4'h4;
  localparam logic [3:0] OPS_MAX = 4'hf;
endpackage

// file: hw/sfci_sync.sv
/*
  Two-flop synchroniser for a bundle of pin levels.
  Assumes each bit is an independent level from outside the clock domain.
*/
`timescale 1ns/1ns
module sfci_sync #(
  parameter int W = 1
) (
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  input wire logic [W-1:0] D_I,
  output logic [W-1:0] Q_O
);
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic meta_reg;
      logic meta_next;
      logic sync_reg;
      logic sync_next;
      always_comb
      begin
        meta_next = D_I[i];
        sync_next = meta_reg;
      end
      always_ff @(posedge SYS_CLK_I)
      begin
        if (RESET_I)
        begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end
        else
        begin
          meta_reg <= meta_next;
          sync_reg <= sync_next;
        end
      end
      assign Q_O[i] = sync_reg;
    end
  endgenerate
endmodule
